// *** src/frf_defines.svh ***
`ifndef FRF_DEFINES_SVH
`define FRF_DEFINES_SVH

// Storage geometry: 512 words of 18 bits, seen as 1024 units of 9 bits
`define FRF_WORDS 512
`define FRF_WORD_W 18
`define FRF_UNITS 11'h400
`define FRF_UNIT_W 9
`define FRF_LANES 4
`define FRF_DATA_W 36
`define FRF_ADDR_W 10
`define FRF_PTR_W 11

// Units moved per access for each port width
`define FRF_U9 3'h1
`define FRF_U18 3'h2
`define FRF_U36 3'h4

// Lane enables for each port width
`define FRF_L9 4'h1
`define FRF_L18 4'h3
`define FRF_L36 4'hF

// Fill level: count bits shown on the 4-bit level outputs
`define FRF_LVL_MSB 9
`define FRF_LVL_LSB 6
`define FRF_LVL_FULL 4'hF
`define FRF_LVL_ZERO 4'h0

// Staging buffer in front of the storage: width tag plus data
`define FRF_STAGE_W 38
`define FRF_STAGE_D 8

`endif

// *** src/frf_pkg.sv ***
package frf_pkg;

  // Operating mode of the block
  typedef enum logic [1:0] {
    FRF_RAM,
    FRF_SYNC,
    FRF_ASYNC
  } frf_mode_t;

  // Data width of one port
  typedef enum logic [1:0] {
    FRF_W9,
    FRF_W18,
    FRF_W36
  } frf_width_t;

endpackage : frf_pkg

// *** src/frf_stage_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "frf_defines.svh"

module frf_stage_fifo #(
  parameter int W = `FRF_STAGE_W,
  parameter int D = `FRF_STAGE_D
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic clr_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = D[AW:0];

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } frf_sf_t;

  frf_sf_t r, n;
  logic [W-1:0] mem [0:D-1];
  logic acc, take;

  // Ready is a flop so the filling side sees a clean level
  always_comb begin
    acc = in_valid_i & r.rdy;
    take = out_valid_o & out_ready_i;
    n = r;
    if (acc) n.wp = r.wp + 1'h1;
    if (take) n.rp = r.rp + 1'h1;
    n.cnt = r.cnt + {{AW{1'h0}}, acc} - {{AW{1'h0}}, take};
    n.rdy = (n.cnt != FULL);
    if (clr_i) begin
      n = '0;
      n.rdy = 1'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r <= '0;
      r.rdy <= 1'h1;
    end else begin
      r <= n;
    end
  end

  // Entry storage, written only on accept
  always_ff @(posedge clk_i) begin
    if (acc) mem[r.wp] <= in_data_i;
  end

  assign in_ready_o = r.rdy;
  assign out_valid_o = (r.cnt != '0);
  assign out_data_o = mem[r.rp];

endmodule : frf_stage_fifo
`default_nettype wire

// *** src/frf_ram.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "frf_defines.svh"

module frf_ram (
  // Clock
  input wire logic clk_i,
  // Write side, unit addressed
  input wire logic we_i,
  input wire logic [`FRF_ADDR_W-1:0] waddr_i,
  input wire logic [`FRF_LANES-1:0] wlanes_i,
  input wire logic [`FRF_DATA_W-1:0] wdata_i,
  // Read side, unit addressed
  input wire logic [`FRF_ADDR_W-1:0] raddr_i,
  output logic [`FRF_DATA_W-1:0] rdata_o
);

  // 512 x 18 array, each word holding two 9-bit units
  logic [`FRF_WORD_W-1:0] mem [0:`FRF_WORDS-1];
  logic [`FRF_ADDR_W-1:0] wa [0:`FRF_LANES-1];

  // Each lane touches the unit after the previous one, wrapping at the top
  for (genvar i = 0; i < `FRF_LANES; i++) begin : g_lane
    logic [`FRF_ADDR_W-1:0] ra;
    assign wa[i] = waddr_i + `FRF_ADDR_W'(i);
    assign ra = raddr_i + `FRF_ADDR_W'(i);
    assign rdata_o[i*`FRF_UNIT_W +: `FRF_UNIT_W] =
      mem[ra[`FRF_ADDR_W-1:1]][ra[0]*`FRF_UNIT_W +: `FRF_UNIT_W];
  end

  // Lane enables act as unit write enables
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < `FRF_LANES; i++) begin
      if (we_i && wlanes_i[i])
        mem[wa[i][`FRF_ADDR_W-1:1]][wa[i][0]*`FRF_UNIT_W +: `FRF_UNIT_W] <=
          wdata_i[i*`FRF_UNIT_W +: `FRF_UNIT_W];
    end
  end

endmodule : frf_ram
`default_nettype wire

// *** src/frf_block.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "frf_defines.svh"

module frf_block import frf_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Configuration
  input wire frf_mode_t mode_i,
  input wire logic dir_i,
  input wire logic pipe_i,
  input wire logic flush_i,
  input wire logic flush_inv_i,
  input wire logic cs_i,
  // Port A
  input wire logic a_clk_i,
  input wire logic a_clk_inv_i,
  input wire frf_width_t a_width_i,
  input wire logic a_en_i,
  input wire logic [`FRF_ADDR_W-1:0] a_addr_i,
  input wire logic [`FRF_DATA_W-1:0] a_wdata_i,
  output logic [`FRF_DATA_W-1:0] a_rdata_o,
  output logic [3:0] a_lvl_o,
  // Port B
  input wire logic b_clk_i,
  input wire logic b_clk_inv_i,
  input wire frf_width_t b_width_i,
  input wire logic b_en_i,
  input wire logic [`FRF_ADDR_W-1:0] b_addr_i,
  input wire logic [`FRF_DATA_W-1:0] b_wdata_i,
  output logic [`FRF_DATA_W-1:0] b_rdata_o,
  output logic [3:0] b_lvl_o,
  // Push side back-pressure
  output logic push_rdy_o
);

  typedef struct packed {
    logic a_clk_q;
    logic b_clk_q;
    logic [`FRF_PTR_W-1:0] wr_ptr;
    logic [`FRF_PTR_W-1:0] rd_ptr;
    logic [`FRF_DATA_W-1:0] pipe;
    logic [`FRF_DATA_W-1:0] a_rdata;
    logic [`FRF_DATA_W-1:0] b_rdata;
    logic [3:0] a_lvl;
    logic [3:0] b_lvl;
  } frf_ctl_t;

  frf_ctl_t r, n;

  logic a_edge, b_edge, push_edge, own_pop_edge, pop_edge;
  logic fifo_on, flush_act, push_en, pop_en;
  frf_width_t push_w, pop_w, st_w;
  logic [2:0] pop_u, st_u;
  logic [`FRF_ADDR_W-1:0] push_addr, pop_addr;
  logic [`FRF_DATA_W-1:0] push_data, pop_word, out_word;
  logic [`FRF_PTR_W-1:0] count, room;
  logic [3:0] lvl_now;
  logic pop_ok, ram_push, ram_pop, rd_take, drain;
  logic st_in_valid, st_out_valid, st_out_ready;
  logic [`FRF_STAGE_W-1:0] st_in_data, st_out_data;
  logic ram_we;
  logic [`FRF_ADDR_W-1:0] ram_waddr, ram_raddr;
  logic [`FRF_LANES-1:0] ram_lanes;
  logic [`FRF_DATA_W-1:0] ram_wdata, ram_rdata;

  // Units per access for a port width
  function automatic logic [2:0] units_of(input frf_width_t w);
    case (w)
      FRF_W9: units_of = `FRF_U9;
      FRF_W18: units_of = `FRF_U18;
      default: units_of = `FRF_U36;
    endcase
  endfunction : units_of

  // Lane enables for a port width
  function automatic logic [`FRF_LANES-1:0] lanes_of(input frf_width_t w);
    case (w)
      FRF_W9: lanes_of = `FRF_L9;
      FRF_W18: lanes_of = `FRF_L18;
      default: lanes_of = `FRF_L36;
    endcase
  endfunction : lanes_of

  // Data mask; unused upper lanes read as zero
  function automatic logic [`FRF_DATA_W-1:0] mask_of(input frf_width_t w);
    logic [`FRF_LANES-1:0] l;
    l = lanes_of(w);
    for (int i = 0; i < `FRF_LANES; i++) begin
      mask_of[i*`FRF_UNIT_W +: `FRF_UNIT_W] = {`FRF_UNIT_W{l[i]}};
    end
  endfunction : mask_of

  // Port clocks are plain samples, so they must run below half the clk_i rate
  // Port clock edges; inversion picks the falling edge instead
  always_comb begin
    a_edge = a_clk_inv_i ? (r.a_clk_q & ~a_clk_i) : (~r.a_clk_q & a_clk_i);
    b_edge = b_clk_inv_i ? (r.b_clk_q & ~b_clk_i) : (~r.b_clk_q & b_clk_i);
  end

  // Role selection; direction swaps push and pop ports
  always_comb begin
    fifo_on = (mode_i != FRF_RAM);
    flush_act = flush_i ^ flush_inv_i;
    push_edge = dir_i ? b_edge : a_edge;
    own_pop_edge = dir_i ? a_edge : b_edge;
    // Synchronous mode runs both sides off the push clock
    pop_edge = (mode_i == FRF_SYNC) ? push_edge : own_pop_edge;
    push_en = dir_i ? b_en_i : a_en_i;
    pop_en = dir_i ? a_en_i : b_en_i;
    push_w = dir_i ? b_width_i : a_width_i;
    pop_w = dir_i ? a_width_i : b_width_i;
    push_addr = dir_i ? b_addr_i : a_addr_i;
    pop_addr = dir_i ? a_addr_i : b_addr_i;
    push_data = dir_i ? b_wdata_i : a_wdata_i;
    pop_u = units_of(pop_w);
  end

  // Pointers carry one extra bit so a full store and an empty one differ
  // Occupancy in 9-bit units and the coarse level view
  always_comb begin
    count = r.wr_ptr - r.rd_ptr;
    room = `FRF_UNITS - count;
    lvl_now = count[`FRF_PTR_W-1] ? `FRF_LVL_FULL : count[`FRF_LVL_MSB:`FRF_LVL_LSB];
  end

  // Buffer hides the storage write slot from the push port's timing
  // Pushes enter the staging buffer with their width tag attached
  always_comb begin
    st_in_valid = fifo_on & push_edge & push_en & ~flush_act;
    st_in_data = {push_w, push_data};
    st_w = frf_width_t'(st_out_data[`FRF_STAGE_W-1:`FRF_DATA_W]);
    st_u = units_of(st_w);
    // Drain only when the whole word fits; partial writes never happen
    st_out_ready = fifo_on & ~flush_act & (room >= {8'h00, st_u});
    drain = st_out_valid & st_out_ready;
  end

  frf_stage_fifo #(
    .W(`FRF_STAGE_W),
    .D(`FRF_STAGE_D)
  ) u_stage (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clr_i(flush_act),
    .in_valid_i(st_in_valid),
    .in_ready_o(push_rdy_o),
    .in_data_i(st_in_data),
    .out_valid_o(st_out_valid),
    .out_ready_i(st_out_ready),
    .out_data_o(st_out_data)
  );

  // RAM mode ignores the pointers; the ports address storage directly
  // Access decode for both FIFO and RAM modes
  always_comb begin
    pop_ok = fifo_on & ~flush_act & pop_edge & pop_en & (count >= {8'h00, pop_u});
    ram_push = ~fifo_on & push_edge & push_en & cs_i;
    ram_pop = ~fifo_on & pop_edge & pop_en;
    rd_take = pop_ok | ram_pop;
    ram_we = drain | ram_push;
    ram_waddr = fifo_on ? r.wr_ptr[`FRF_ADDR_W-1:0] : push_addr;
    ram_lanes = fifo_on ? lanes_of(st_w) : lanes_of(push_w);
    ram_wdata = fifo_on ? st_out_data[`FRF_DATA_W-1:0] : push_data;
    ram_raddr = fifo_on ? r.rd_ptr[`FRF_ADDR_W-1:0] : pop_addr;
    // Deselected block reads zero in RAM mode so stacked blocks can be ORed; FIFO modes ignore cs_i
    pop_word = (fifo_on | cs_i) ? (ram_rdata & mask_of(pop_w)) : '0;
    // Pipelined read hands out the previous word
    out_word = pipe_i ? r.pipe : pop_word;
  end

  frf_ram u_ram (
    .clk_i(clk_i),
    .we_i(ram_we),
    .waddr_i(ram_waddr),
    .wlanes_i(ram_lanes),
    .wdata_i(ram_wdata),
    .raddr_i(ram_raddr),
    .rdata_o(ram_rdata)
  );

  // Next state: pointers, read registers, per-port levels
  always_comb begin
    n = r;
    n.a_clk_q = a_clk_i;
    n.b_clk_q = b_clk_i;
    if (drain) n.wr_ptr = r.wr_ptr + {8'h00, st_u};
    if (pop_ok) n.rd_ptr = r.rd_ptr + {8'h00, pop_u};
    if (rd_take) begin
      n.pipe = pop_word;
      if (dir_i) n.a_rdata = out_word;
      else n.b_rdata = out_word;
    end
    // Each level follows its own port's clock; in synchronous mode both follow the push clock
    // Port A pops when the direction is swapped, so it follows the pop edge then
    if (fifo_on && (dir_i ? pop_edge : push_edge)) n.a_lvl = lvl_now;
    if (fifo_on && (dir_i ? push_edge : pop_edge)) n.b_lvl = lvl_now;
    // Flush is sampled by clk_i, so a pulse that spans no rising edge of clk_i is lost
    // Flush wins over any push or pop in the same cycle in the FIFO modes; RAM mode accesses still go ahead
    if (flush_act) begin
      n.wr_ptr = '0;
      n.rd_ptr = '0;
      n.pipe = '0;
      n.a_lvl = `FRF_LVL_ZERO;
      n.b_lvl = `FRF_LVL_ZERO;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) r <= '0;
    else r <= n;
  end

  assign a_rdata_o = r.a_rdata;
  assign b_rdata_o = r.b_rdata;
  assign a_lvl_o = r.a_lvl;
  assign b_lvl_o = r.b_lvl;

  // Checks
  // Levels and read data are checked one cycle after the edge that moves them
  property p_pop_empty;
    @(posedge clk_i) disable iff (!rstn_i)
      (fifo_on && pop_edge && pop_en && !flush_act && count < {8'h00, pop_u})
      |=> (r.rd_ptr == $past(r.rd_ptr));
  endproperty
  a_pop_empty: assert property (p_pop_empty) else $error("pop on empty moved pointer");

  property p_wr_only_drain;
    @(posedge clk_i) disable iff (!rstn_i)
      (!drain && !flush_act) |=> $stable(r.wr_ptr);
  endproperty
  a_wr_only_drain: assert property (p_wr_only_drain) else $error("write pointer moved");

  property p_flush;
    @(posedge clk_i) disable iff (!rstn_i)
      flush_act |=> (count == '0 && a_lvl_o == `FRF_LVL_ZERO && b_lvl_o == `FRF_LVL_ZERO);
  endproperty
  a_flush: assert property (p_flush) else $error("flush did not empty");

  property p_pop_clock;
    @(posedge clk_i) disable iff (!rstn_i)
      (r.rd_ptr != $past(r.rd_ptr) && !$past(flush_act)) |-> $past(pop_edge);
  endproperty
  a_pop_clock: assert property (p_pop_clock) else $error("pop off its clock");

  property p_pop_step;
    @(posedge clk_i) disable iff (!rstn_i)
      pop_ok |=> (r.rd_ptr - $past(r.rd_ptr)) == {8'h00, $past(pop_u)};
  endproperty
  a_pop_step: assert property (p_pop_step) else $error("pop step wrong");

  property p_dir_swap;
    @(posedge clk_i) disable iff (!rstn_i)
      (pop_ok && dir_i && !pipe_i) |=> (a_rdata_o == $past(pop_word)) && $stable(b_rdata_o);
  endproperty
  a_dir_swap: assert property (p_dir_swap) else $error("direction swap wrong");

  property p_pipe_lag;
    @(posedge clk_i) disable iff (!rstn_i)
      (rd_take && pipe_i && !dir_i) |=> (b_rdata_o == $past(r.pipe));
  endproperty
  a_pipe_lag: assert property (p_pipe_lag) else $error("pipelined read wrong");

  property p_level;
    @(posedge clk_i) disable iff (!rstn_i)
      (fifo_on && pop_edge && !dir_i && !flush_act) |=> (b_lvl_o == $past(lvl_now));
  endproperty
  a_level: assert property (p_level) else $error("pop level wrong");

  property p_ram_still;
    @(posedge clk_i) disable iff (!rstn_i)
      (mode_i == FRF_RAM && !flush_act) |=> $stable(r.rd_ptr) && $stable(r.wr_ptr);
  endproperty
  a_ram_still: assert property (p_ram_still) else $error("pointers moved in RAM mode");

  property p_cs_zero;
    @(posedge clk_i) disable iff (!rstn_i)
      (ram_pop && !cs_i && !pipe_i && !dir_i) |=> (b_rdata_o == '0);
  endproperty
  a_cs_zero: assert property (p_cs_zero) else $error("deselected read not zero");

  property p_level_push;
    @(posedge clk_i) disable iff (!rstn_i)
      (fifo_on && push_edge && !dir_i && !flush_act) |=> (a_lvl_o == $past(lvl_now));
  endproperty
  a_level_push: assert property (p_level_push) else $error("push level wrong");

  property p_count_max;
    @(posedge clk_i) disable iff (!rstn_i)
      count <= `FRF_UNITS;
  endproperty
  a_count_max: assert property (p_count_max) else $error("occupancy too high");

  property p_rdata_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      !rd_take |=> $stable(a_rdata_o) && $stable(b_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_flush_ready;
    @(posedge clk_i) disable iff (!rstn_i)
      flush_act |=> push_rdy_o;
  endproperty
  a_flush_ready: assert property (p_flush_ready) else $error("flush left buffer full");

  property p_upper_zero;
    @(posedge clk_i) disable iff (!rstn_i)
      (pop_ok && pop_w == FRF_W9 && !pipe_i && !dir_i)
      |=> (b_rdata_o[`FRF_DATA_W-1:`FRF_UNIT_W] == '0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unused lanes not zero");

  // Scenario covers
  c_push: cover property (@(posedge clk_i) disable iff (!rstn_i) st_in_valid && push_rdy_o);
  c_pop: cover property (@(posedge clk_i) disable iff (!rstn_i) pop_ok);
  c_refused: cover property (@(posedge clk_i) disable iff (!rstn_i) st_in_valid && !push_rdy_o);
  c_flush: cover property (@(posedge clk_i) disable iff (!rstn_i) flush_act && count != '0);
  c_full: cover property (@(posedge clk_i) disable iff (!rstn_i) count[`FRF_PTR_W-1]);

endmodule : frf_block
`default_nettype wire

// *** tb/frf_user_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module frf_user_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Request from the bench
  input wire logic go_i,
  input wire logic en_i,
  // Port strobes
  output logic pclk_o,
  output logic pen_o,
  output logic done_o
);
  logic [1:0] ph_r;

  // Rise then fall with the strobe held over both, so either edge acts
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ph_r <= 2'h0;
      pclk_o <= 1'h0;
      pen_o <= 1'h0;
      done_o <= 1'h0;
    end else begin
      done_o <= (ph_r == 2'h2);
      if (ph_r == 2'h0 && go_i) begin
        ph_r <= 2'h1;
        pclk_o <= 1'h1;
        pen_o <= en_i;
      end else if (ph_r == 2'h1) begin
        ph_r <= 2'h2;
        pclk_o <= 1'h0;
      end else if (ph_r == 2'h2) begin
        ph_r <= 2'h0;
        pen_o <= 1'h0;
      end
    end
  end
endmodule : frf_user_model
`default_nettype wire

// *** tb/frf_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench import frf_pkg::*;;
  localparam logic [35:0] WD = {9'h1A4, 9'h0C3, 9'h15B, 9'h02E};
  logic clk, rstn, dir, pipe, fl, fi, cs, ai, bi, prdy;
  logic ago, aen, ack, aep, adn, bgo, ben, bck, bep, bdn;
  frf_mode_t mode;
  frf_width_t aw, bw;
  logic [9:0] aa, ba;
  logic [35:0] awd, bwd, ard, brd;
  logic [3:0] al, bl;
  int fail_count, num_checks, i;

  frf_block DUT (.clk_i(clk), .rstn_i(rstn), .mode_i(mode), .dir_i(dir),
    .pipe_i(pipe), .flush_i(fl), .flush_inv_i(fi), .cs_i(cs),
    .a_clk_i(ack), .a_clk_inv_i(ai), .a_width_i(aw), .a_en_i(aep),
    .a_addr_i(aa), .a_wdata_i(awd), .a_rdata_o(ard), .a_lvl_o(al),
    .b_clk_i(bck), .b_clk_inv_i(bi), .b_width_i(bw), .b_en_i(bep),
    .b_addr_i(ba), .b_wdata_i(bwd), .b_rdata_o(brd), .b_lvl_o(bl),
    .push_rdy_o(prdy));
  frf_user_model u_a (.clk_i(clk), .rstn_i(rstn), .go_i(ago), .en_i(aen),
    .pclk_o(ack), .pen_o(aep), .done_o(adn));
  frf_user_model u_b (.clk_i(clk), .rstn_i(rstn), .go_i(bgo), .en_i(ben),
    .pclk_o(bck), .pen_o(bep), .done_o(bdn));

  // Free running system clock
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // One port access per side; both may run together for sync pops
  task automatic acc(input logic ga, ea, gb, eb, input logic [35:0] d);
    int n;
    @(posedge clk);
    ago <= ga;
    aen <= ea;
    bgo <= gb;
    ben <= eb;
    awd <= d;
    bwd <= d;
    @(posedge clk);
    ago <= 1'h0;
    bgo <= 1'h0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!(adn | bdn) && n < 9);
    // Extra cycle covers an inverted port acting on the fall
    @(posedge clk);
    #1;
    if (n >= 9) begin
      fail_count++;
      $display("[ERR] %0t port hang", $time);
      final_report();
    end
  endtask : acc

  // Flush idles at the inactive level of the chosen polarity
  task automatic fls();
    @(posedge clk);
    fl <= ~fi;
    @(posedge clk);
    fl <= fi;
    @(posedge clk);
  endtask : fls

  initial begin
    {rstn, dir, pipe, fl, fi, cs, ai, bi, ago, aen, bgo, ben} = '0;
    mode = FRF_ASYNC;
    aw = FRF_W36;
    bw = FRF_W9;
    {aa, ba, awd, bwd} = '0;
    fail_count = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    #1;
    chk({ard[26:0], prdy, al, bl}, {27'h0, 1'h1, 8'h00});
    chk(brd, 36'h0);
    // Wide push, narrow pops, lowest unit first; pops follow data
    acc(1, 1, 0, 0, WD);
    for (i = 0; i < 4; i++) begin
      acc(0, 0, 1, 1, 36'h0);
      chk(brd, {27'h0, WD[i*9 +: 9]});
    end
    acc(0, 0, 1, 1, 36'h0);
    chk(brd, {27'h0, WD[35:27]});
    // Half word pops, second on the falling edge of port B
    @(posedge clk);
    bw <= FRF_W18;
    acc(1, 1, 0, 0, WD);
    acc(0, 0, 1, 1, 36'h0);
    chk(brd, {18'h0, WD[17:0]});
    @(posedge clk);
    bi <= 1'h1;
    acc(0, 0, 1, 1, 36'h0);
    chk(brd, {18'h0, WD[35:18]});
    @(posedge clk);
    bi <= 1'h0;
    // Flush in both polarities leaves nothing to pop
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      fi <= i[0];
      fl <= i[0];
      acc(1, 1, 0, 0, WD);
      fls();
      acc(0, 0, 1, 1, 36'h0);
      chk(brd, {18'h0, WD[35:18]});
    end
    // Registered read shows the word one pop late
    @(posedge clk);
    pipe <= 1'h1;
    fls();
    acc(1, 1, 0, 0, WD);
    acc(0, 0, 1, 1, 36'h0);
    chk(brd, 36'h0);
    acc(0, 0, 1, 1, 36'h0);
    chk(brd, {18'h0, WD[17:0]});
    @(posedge clk);
    pipe <= 1'h0;
    dir <= 1'h1;
    bw <= FRF_W36;
    ai <= 1'h1;
    fls();
    // Swapped roles: B pushes, A pops on its falling edge
    acc(0, 0, 1, 1, WD);
    acc(1, 1, 0, 0, 36'h0);
    chk(ard, WD);
    @(posedge clk);
    dir <= 1'h0;
    ai <= 1'h0;
    // Fill storage and staging until refused
    for (i = 0; i < 264; i++) begin
      acc(1, 1, 0, 0, 36'(i));
    end
    chk({32'h0, al}, 36'hF);
    chk({35'h0, prdy}, 36'h0);
    acc(1, 1, 0, 0, 36'hABC);
    for (i = 0; i < 264; i++) begin
      acc(0, 0, 1, 1, 36'h0);
      chk(brd, 36'(i));
      if (i == 0) begin
        chk({32'h0, bl}, 36'hF);
      end
    end
    acc(0, 0, 1, 1, 36'h0);
    chk(brd, 36'(263));
    chk({32'h0, bl}, 36'h0);
    // Sync mode: B pops only on the push port's edge
    @(posedge clk);
    mode <= FRF_SYNC;
    fls();
    acc(1, 1, 0, 0, WD);
    acc(0, 0, 1, 1, 36'h0);
    chk(brd, 36'(263));
    acc(1, 0, 1, 1, 36'h0);
    chk(brd, WD);
    // RAM mode with mixed widths and chip select
    @(posedge clk);
    mode <= FRF_RAM;
    cs <= 1'h1;
    aw <= FRF_W18;
    bw <= FRF_W9;
    aa <= 10'h005;
    ba <= 10'h006;
    acc(1, 1, 0, 0, WD);
    acc(0, 0, 1, 1, 36'h0);
    chk(brd, {27'h0, WD[17:9]});
    @(posedge clk);
    cs <= 1'h0;
    acc(0, 0, 1, 1, 36'h0);
    chk(brd, 36'h0);
    // Registered RAM read lags by one access
    @(posedge clk);
    cs <= 1'h1;
    pipe <= 1'h1;
    acc(0, 0, 1, 1, 36'h0);
    chk(brd, 36'h0);
    acc(0, 0, 1, 1, 36'h0);
    chk(brd, {27'h0, WD[17:9]});
    final_report();
  end
endmodule : testbench
`default_nettype wire
